// File: logic/cpr_adder.sv
// Eight-bit adder with carry in, giving sum, half carry and carry out.
// Assumes operands from flip-flops of the same clock; purely combinational.
`timescale 1ns/100ps
`default_nettype none

module cpr_adder (
    // Operands
    input wire logic [7:0] opnd_a_in,
    input wire logic [7:0] opnd_b_in,
    input wire logic carry_in,
    // Results
    output logic [7:0] sum_out,
    output logic half_out,
    output logic carry_out
);
    logic [8:0] full;
    logic [4:0] low;

    assign full = {1'b0, opnd_a_in} + {1'b0, opnd_b_in} + {8'h00, carry_in};
    assign low = {1'b0, opnd_a_in[3:0]} + {1'b0, opnd_b_in[3:0]} + {4'h0, carry_in};
    assign sum_out = full[7:0];
    assign carry_out = full[8];
    // Carry out of bit 3 into bit 4.
    assign half_out = low[4];

endmodule : cpr_adder

`default_nettype wire

// File: logic/cpr_defines.svh
// Constants for the CPU register file: reset values, flag positions,
// stack geometry and context-save lengths.
// Assumes inclusion by bare name from the register file module.
`ifndef CPR_DEFINES_SVH
`define CPR_DEFINES_SVH

// ==========================================================
// Condition code layout
`define CPR_CC_RST 8'hE8
`define CPR_CC_HI_ONES 3'h7
`define CPR_FLAG_H 4
`define CPR_FLAG_I 3
`define CPR_FLAG_N 2
`define CPR_FLAG_Z 1
`define CPR_FLAG_C 0
`define CPR_SIGN_BIT 7

// ==========================================================
// Stack geometry
`define CPR_SP_FIXED_HI 10'h003
`define CPR_SP_TOP 6'h3F
`define CPR_SP_RST 16'h00FF

// ==========================================================
// Context save lengths in bytes
`define CPR_LEN_ONE 3'h1
`define CPR_LEN_CALL 3'h2
`define CPR_LEN_INT 3'h5

// ==========================================================
// Reset values of data registers
`define CPR_DATA_RST 8'h00
`define CPR_PC_RST 16'h0000

`endif

// File: logic/cpr_pkg.sv
// Types shared by the CPU register file modules.
// Assumes the defines header sits beside it.
package cpr_pkg;

    // ==========================================================
    // Register selectors
    typedef enum logic [2:0] {
        REG_A,
        REG_X,
        REG_Y,
        REG_PCL,
        REG_PCH,
        REG_CC,
        REG_SL
    } cpr_reg_t;

    // ==========================================================
    // Stack operations
    typedef enum logic [2:0] {
        STK_NONE,
        STK_PUSH,
        STK_POP,
        STK_CALL,
        STK_RET,
        STK_INT,
        STK_INTERRUPT_RETURN_INSTR
    } cpr_stk_t;

    // ==========================================================
    // Stack sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PUSH,
        ST_POP_INC,
        ST_POP_RD
    } cpr_state_t;

endpackage : cpr_pkg

// File: logic/cpr_regs.sv
// CPU programmer-visible registers: accumulator, two index registers,
// program counter, condition codes and a 64-byte stack pointer with a
// push/pop sequencer for calls and interrupt context.
// Assumes the execution logic on the same clock drives the commands,
// issues them only while busy_out is low, and owns the stack RAM,
// which reads combinationally at stack_addr_out.
//
// Notes on behaviour
// RULE_01 - Eight-bit accumulator holds operands and results of data operations.
// RULE_02 - Two eight-bit index registers for addressing or temporary data.
// RULE_03 - Second index register is never pushed or popped for interrupts.
// RULE_04 - Sixteen-bit program counter with separately writable low and high bytes.
// RULE_05 - Condition codes hold mask and four flags; reset pattern 111x1xxx.
// RULE_06 - Add operations set half carry on carry from bit 3 to 4.
// RULE_07 - Mask set on entry or instruction, cleared by software, restored on return.
// RULE_08 - Requests arriving while masked are latched and served once unmasked.
// RULE_09 - Clearing mask in a handler serves pending requests regardless of priority.
// RULE_10 - Negative flag copies bit 7 of each data operation result.
// RULE_11 - Zero flag set when the result is zero, else cleared.
// RULE_12 - Carry set on overflow; forced by instructions; shifts and tests update it.
// RULE_13 - Whole condition code register can be pushed and popped.
// RULE_14 - Stack pointer points to free slot; decrement after push, increment before pop.
// RULE_15 - Upper ten stack pointer bits fixed, six low bits vary.
// RULE_16 - Reset and stack reset instruction set the six low bits to ones.
// RULE_17 - Stack pointer wraps silently at both limits.
// RULE_18 - Interrupt entry writes program counter low byte first, then the rest.
// RULE_19 - Call uses two stack bytes, interrupt context uses five.
// RULE_20 - Stack pointer low byte readable and writable by load.
// RULE_21 - Flags update in the same cycle as the result write-back.
`timescale 1ns/100ps
`default_nettype none
`include "cpr_defines.svh"

module cpr_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Plain register load
    input wire logic wr_en_in,
    input wire cpr_pkg::cpr_reg_t wr_sel_in,
    input wire logic [7:0] wr_data_in,
    // Result write-back with flag update
    input wire logic res_we_in,
    input wire cpr_pkg::cpr_reg_t res_sel_in,
    input wire logic [7:0] res_data_in,
    input wire logic add_go_in,
    input wire logic add_with_carry_in,
    input wire logic [7:0] add_opnd_in,
    // Flag instructions
    input wire logic set_mask_instr_in,
    input wire logic clear_mask_instr_in,
    input wire logic set_carry_instr_in,
    input wire logic clear_carry_instr_in,
    input wire logic carry_wr_in,
    input wire logic carry_val_in,
    // Program counter control
    input wire logic pc_we_in,
    input wire logic [15:0] pc_load_in,
    input wire logic pc_inc_in,
    // Stack commands
    input wire logic reset_stack_pointer_instr_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire cpr_pkg::cpr_reg_t stk_sel_in,
    input wire logic call_in,
    input wire logic ret_in,
    input wire logic irq_enter_in,
    input wire logic trap_enter_in,
    input wire logic interrupt_return_instr_in,
    input wire logic [7:0] stack_rdata_in,
    // Interrupt request
    input wire logic irq_req_in,
    // Register views
    output logic [7:0] acc_out,
    output logic [7:0] idx_x_out,
    output logic [7:0] idx_y_out,
    output logic [15:0] program_counter_out,
    output logic [7:0] condition_code_register_out,
    output logic [15:0] stack_pointer_out,
    // Stack RAM port and status
    output logic busy_out,
    output logic stack_we_out,
    output logic [15:0] stack_addr_out,
    output logic [7:0] stack_wdata_out,
    output logic irq_pending_out,
    output logic irq_service_out
);
    // ==========================================================
    // Storage
    logic [7:0] acc_ff;
    logic [7:0] idx_x_ff;
    logic [7:0] idx_y_ff;
    logic [15:0] pc_ff;
    logic [4:0] cc_ff;
    logic [4:0] nxt_cc;
    logic [5:0] sp_ff;
    logic pend_ff;
    cpr_pkg::cpr_state_t state_ff;
    cpr_pkg::cpr_stk_t op_ff;
    cpr_pkg::cpr_stk_t start_op;
    cpr_pkg::cpr_reg_t sel_ff;
    cpr_pkg::cpr_reg_t cur_reg;
    logic [2:0] idx_ff;
    logic last_step;
    logic uw_en;
    cpr_pkg::cpr_reg_t uw_sel;
    logic [7:0] uw_data;
    logic [7:0] add_sum;
    logic add_half;
    logic add_carry;

    // ==========================================================
    // Helper functions
    function automatic cpr_pkg::cpr_reg_t seq_reg(input cpr_pkg::cpr_stk_t op,
                                                   input logic [2:0] idx,
                                                   input cpr_pkg::cpr_reg_t sel);
        cpr_pkg::cpr_reg_t r;
        r = sel;
        case (op)
            cpr_pkg::STK_CALL: r = (idx == 3'h0) ? cpr_pkg::REG_PCL : cpr_pkg::REG_PCH;
            cpr_pkg::STK_RET: r = (idx == 3'h0) ? cpr_pkg::REG_PCH : cpr_pkg::REG_PCL;
            // RULE_18 - low byte first
            cpr_pkg::STK_INT:
            begin
                case (idx)
                    3'h0: r = cpr_pkg::REG_PCL;
                    3'h1: r = cpr_pkg::REG_PCH;
                    3'h2: r = cpr_pkg::REG_X;
                    3'h3: r = cpr_pkg::REG_A;
                    default: r = cpr_pkg::REG_CC;
                endcase
            end
            // RULE_03 - no second index
            cpr_pkg::STK_INTERRUPT_RETURN_INSTR:
            begin
                case (idx)
                    3'h0: r = cpr_pkg::REG_CC;
                    3'h1: r = cpr_pkg::REG_A;
                    3'h2: r = cpr_pkg::REG_X;
                    3'h3: r = cpr_pkg::REG_PCH;
                    default: r = cpr_pkg::REG_PCL;
                endcase
            end
            default: r = sel;
        endcase
        return r;
    endfunction : seq_reg

    // RULE_19 - bytes per save
    function automatic logic [2:0] seq_len(input cpr_pkg::cpr_stk_t op);
        case (op)
            cpr_pkg::STK_CALL, cpr_pkg::STK_RET: return `CPR_LEN_CALL;
            cpr_pkg::STK_INT, cpr_pkg::STK_INTERRUPT_RETURN_INSTR: return `CPR_LEN_INT;
            default: return `CPR_LEN_ONE;
        endcase
    endfunction : seq_len

    function automatic logic [7:0] reg_val(input cpr_pkg::cpr_reg_t r);
        case (r)
            cpr_pkg::REG_A: return acc_ff;
            cpr_pkg::REG_X: return idx_x_ff;
            cpr_pkg::REG_Y: return idx_y_ff;
            cpr_pkg::REG_PCL: return pc_ff[7:0];
            cpr_pkg::REG_PCH: return pc_ff[15:8];
            // RULE_13 - whole byte saved
            cpr_pkg::REG_CC: return {`CPR_CC_HI_ONES, cc_ff};
            default: return {2'h0, sp_ff};
        endcase
    endfunction : reg_val

    // ==========================================================
    // Adder
    cpr_adder u_adder (
        .opnd_a_in(acc_ff),
        .opnd_b_in(add_opnd_in),
        .carry_in(add_with_carry_in & cc_ff[`CPR_FLAG_C]),
        .sum_out(add_sum),
        .half_out(add_half),
        .carry_out(add_carry)
    );

    // ==========================================================
    // Stack sequencer
    always_comb
    begin
        start_op = cpr_pkg::STK_NONE;
        if (irq_enter_in || trap_enter_in)
            start_op = cpr_pkg::STK_INT;
        else if (interrupt_return_instr_in)
            start_op = cpr_pkg::STK_INTERRUPT_RETURN_INSTR;
        else if (call_in)
            start_op = cpr_pkg::STK_CALL;
        else if (ret_in)
            start_op = cpr_pkg::STK_RET;
        else if (push_in)
            start_op = cpr_pkg::STK_PUSH;
        else if (pop_in)
            start_op = cpr_pkg::STK_POP;
    end

    assign cur_reg = seq_reg(op_ff, idx_ff, sel_ff);
    assign last_step = (idx_ff == seq_len(op_ff) - 3'h1);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_ff <= cpr_pkg::ST_IDLE;
            op_ff <= cpr_pkg::STK_NONE;
            sel_ff <= cpr_pkg::REG_A;
            idx_ff <= 3'h0;
        end
        else
        begin
            case (state_ff)
                cpr_pkg::ST_IDLE:
                begin
                    idx_ff <= 3'h0;
                    op_ff <= start_op;
                    sel_ff <= stk_sel_in;
                    if (start_op == cpr_pkg::STK_INT || start_op == cpr_pkg::STK_CALL
                        || start_op == cpr_pkg::STK_PUSH)
                        state_ff <= cpr_pkg::ST_PUSH;
                    else if (start_op != cpr_pkg::STK_NONE)
                        state_ff <= cpr_pkg::ST_POP_INC;
                end
                cpr_pkg::ST_PUSH:
                begin
                    idx_ff <= idx_ff + 3'h1;
                    if (last_step)
                        state_ff <= cpr_pkg::ST_IDLE;
                end
                cpr_pkg::ST_POP_INC:
                begin
                    state_ff <= cpr_pkg::ST_POP_RD;
                end
                default:
                begin
                    idx_ff <= idx_ff + 3'h1;
                    state_ff <= last_step ? cpr_pkg::ST_IDLE : cpr_pkg::ST_POP_INC;
                end
            endcase
        end
    end

    assign busy_out = (state_ff != cpr_pkg::ST_IDLE);
    assign stack_we_out = (state_ff == cpr_pkg::ST_PUSH);
    assign stack_addr_out = stack_pointer_out;
    always_comb stack_wdata_out = reg_val(cur_reg);

    // ==========================================================
    // Unified byte write: popped data beats a load, a load beats a result
    always_comb
    begin
        uw_en = 1'b1;
        uw_sel = res_sel_in;
        uw_data = res_data_in;
        if (state_ff == cpr_pkg::ST_POP_RD)
        begin
            uw_sel = cur_reg;
            uw_data = stack_rdata_in;
        end
        else if (wr_en_in)
        begin
            uw_sel = wr_sel_in;
            uw_data = wr_data_in;
        end
        else if (!res_we_in)
            uw_en = 1'b0;
    end

    // ==========================================================
    // Data registers
    // RULE_01 - accumulator update
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            acc_ff <= `CPR_DATA_RST;
        else if (uw_en && uw_sel == cpr_pkg::REG_A)
            acc_ff <= uw_data;
        else if (add_go_in)
            acc_ff <= add_sum;
    end

    // RULE_02 - index registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            idx_x_ff <= `CPR_DATA_RST;
            idx_y_ff <= `CPR_DATA_RST;
        end
        else if (uw_en && uw_sel == cpr_pkg::REG_X)
            idx_x_ff <= uw_data;
        else if (uw_en && uw_sel == cpr_pkg::REG_Y)
            idx_y_ff <= uw_data;
    end

    // RULE_04 - byte-wise program counter
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            pc_ff <= `CPR_PC_RST;
        else if (uw_en && uw_sel == cpr_pkg::REG_PCL)
            pc_ff[7:0] <= uw_data;
        else if (uw_en && uw_sel == cpr_pkg::REG_PCH)
            pc_ff[15:8] <= uw_data;
        else if (pc_we_in)
            pc_ff <= pc_load_in;
        else if (pc_inc_in)
            pc_ff <= pc_ff + 16'h0001;
    end

    // ==========================================================
    // Condition codes
    always_comb
    begin
        nxt_cc = cc_ff;
        // RULE_07 - mask control
        if (set_mask_instr_in)
            nxt_cc[`CPR_FLAG_I] = 1'b1;
        else if (clear_mask_instr_in)
            nxt_cc[`CPR_FLAG_I] = 1'b0;
        if (state_ff == cpr_pkg::ST_PUSH && op_ff == cpr_pkg::STK_INT && last_step)
            nxt_cc[`CPR_FLAG_I] = 1'b1;
        // RULE_12 - carry sources
        if (set_carry_instr_in)
            nxt_cc[`CPR_FLAG_C] = 1'b1;
        else if (clear_carry_instr_in)
            nxt_cc[`CPR_FLAG_C] = 1'b0;
        else if (carry_wr_in)
            nxt_cc[`CPR_FLAG_C] = carry_val_in;
        // RULE_21 - flags with write-back
        if (res_we_in)
        begin
            nxt_cc[`CPR_FLAG_N] = res_data_in[`CPR_SIGN_BIT];
            nxt_cc[`CPR_FLAG_Z] = (res_data_in == 8'h00);
        end
        if (add_go_in)
        begin
            // RULE_06 - half carry
            nxt_cc[`CPR_FLAG_H] = add_half;
            // RULE_10 - sign copy
            nxt_cc[`CPR_FLAG_N] = add_sum[`CPR_SIGN_BIT];
            // RULE_11 - zero detect
            nxt_cc[`CPR_FLAG_Z] = (add_sum == 8'h00);
            nxt_cc[`CPR_FLAG_C] = add_carry;
        end
        // RULE_13 - whole-byte restore
        if (uw_en && uw_sel == cpr_pkg::REG_CC)
            nxt_cc = uw_data[4:0];
    end

    // RULE_05 - reset pattern
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            cc_ff <= 5'(`CPR_CC_RST);
        else
            cc_ff <= nxt_cc;
    end

    // ==========================================================
    // Stack pointer
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            sp_ff <= `CPR_SP_TOP;
        // RULE_16 - back to top
        else if (reset_stack_pointer_instr_in)
            sp_ff <= `CPR_SP_TOP;
        // RULE_20 - load low byte
        else if (uw_en && uw_sel == cpr_pkg::REG_SL)
            sp_ff <= uw_data[5:0];
        // RULE_14 - post-decrement push
        else if (state_ff == cpr_pkg::ST_PUSH)
            sp_ff <= sp_ff - 6'h01;
        // RULE_17 - silent wrap
        else if (state_ff == cpr_pkg::ST_POP_INC)
            sp_ff <= sp_ff + 6'h01;
    end

    // RULE_15 - fixed upper bits
    assign stack_pointer_out = {`CPR_SP_FIXED_HI, sp_ff};

    // ==========================================================
    // Interrupt request latch
    // RULE_08 - latch while masked
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            pend_ff <= 1'b0;
        else if (irq_req_in)
            pend_ff <= 1'b1;
        else if (irq_enter_in)
            pend_ff <= 1'b0;
    end

    assign irq_pending_out = pend_ff;
    // RULE_09 - serve on unmask
    assign irq_service_out = pend_ff & ~cc_ff[`CPR_FLAG_I];

    // ==========================================================
    // Views
    assign acc_out = acc_ff;
    assign idx_x_out = idx_x_ff;
    assign idx_y_out = idx_y_ff;
    assign program_counter_out = pc_ff;
    assign condition_code_register_out = {`CPR_CC_HI_ONES, cc_ff};

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    acc_add_a: assert property (add_go_in && !uw_en |=> acc_out == $past(add_sum)) // RULE_01
        else $error("accumulator missed add result");
    idx_load_a: assert property (wr_en_in && wr_sel_in == cpr_pkg::REG_Y && !busy_out
        |=> idx_y_out == $past(wr_data_in)) // RULE_02
        else $error("index load lost");
    y_never_stacked_a: assert property (op_ff == cpr_pkg::STK_INT && stack_we_out
        |-> cur_reg != cpr_pkg::REG_Y) // RULE_03
        else $error("second index pushed");
    pc_inc_a: assert property (pc_inc_in && !pc_we_in && !busy_out && !(uw_en
        && (uw_sel == cpr_pkg::REG_PCL || uw_sel == cpr_pkg::REG_PCH))
        |=> program_counter_out == $past(program_counter_out) + 16'h0001) // RULE_04
        else $error("pc increment wrong");
    cc_high_ones_a: assert property (condition_code_register_out[7:5] == 3'h7) // RULE_05
        else $error("cc upper bits not ones");
    half_carry_a: assert property (add_go_in && !uw_en
        |=> cc_ff[4] == (5'($past(acc_ff[3:0])) + $past(add_opnd_in[3:0])
        + $past(add_with_carry_in & cc_ff[0]) > 5'h0F)) // RULE_06
        else $error("half carry wrong");
    mask_set_a: assert property (set_mask_instr_in && !uw_en |=> cc_ff[`CPR_FLAG_I]) // RULE_07
        else $error("mask not set");
    irq_latch_a: assert property (irq_req_in |=> irq_pending_out) // RULE_08
        else $error("request not latched");
    irq_serve_a: assert property (pend_ff && !cc_ff[`CPR_FLAG_I] |-> irq_service_out) // RULE_09
        else $error("pending not served");
    neg_flag_a: assert property (res_we_in && !add_go_in && !uw_en_cc()
        |=> cc_ff[`CPR_FLAG_N] == $past(res_data_in[7])) // RULE_10
        else $error("negative flag wrong");
    zero_flag_a: assert property (res_we_in && !add_go_in && !uw_en_cc()
        |=> cc_ff[`CPR_FLAG_Z] == ($past(res_data_in) == 8'h00)) // RULE_11
        else $error("zero flag wrong");
    carry_set_a: assert property (set_carry_instr_in && !add_go_in && !uw_en_cc()
        |=> cc_ff[`CPR_FLAG_C]) // RULE_12
        else $error("carry not forced");
    cc_push_a: assert property (stack_we_out && cur_reg == cpr_pkg::REG_CC
        |-> stack_wdata_out == condition_code_register_out) // RULE_13
        else $error("cc push data wrong");
    sp_push_dec_a: assert property (stack_we_out && !reset_stack_pointer_instr_in
        && !uw_en_sl() |=> sp_ff == $past(sp_ff) - 6'h01) // RULE_14
        else $error("push did not decrement");
    sp_fixed_a: assert property (stack_pointer_out[15:6] == 10'h003) // RULE_15
        else $error("stack pointer upper bits moved");
    sp_rsp_a: assert property (reset_stack_pointer_instr_in |=> stack_pointer_out
        == 16'h00FF) // RULE_16
        else $error("stack reset failed");
    sp_wrap_a: assert property (state_ff == cpr_pkg::ST_POP_INC && sp_ff == 6'h3F
        && !reset_stack_pointer_instr_in |=> sp_ff == 6'h00) // RULE_17
        else $error("no wrap on underflow");
    int_order_a: assert property (state_ff == cpr_pkg::ST_IDLE && start_op
        == cpr_pkg::STK_INT |=> stack_we_out && stack_wdata_out == pc_ff[7:0]) // RULE_18
        else $error("pcl not first");
    int_five_a: assert property (state_ff == cpr_pkg::ST_IDLE && start_op
        == cpr_pkg::STK_INT |=> stack_we_out [*5] ##1 !stack_we_out) // RULE_19
        else $error("interrupt save not five bytes");
    sl_load_a: assert property (wr_en_in && wr_sel_in == cpr_pkg::REG_SL && !busy_out
        && !reset_stack_pointer_instr_in |=> sp_ff == $past(wr_data_in[5:0])) // RULE_20
        else $error("stack low byte load lost");
    flag_same_a: assert property (add_go_in && !uw_en
        |=> cc_ff[`CPR_FLAG_Z] == (acc_out == 8'h00)) // RULE_21
        else $error("flags lag result");

    int_cov_c: cover property (state_ff == cpr_pkg::ST_IDLE && start_op == cpr_pkg::STK_INT);
    interrupt_return_instr_cov_c: cover property (op_ff == cpr_pkg::STK_INTERRUPT_RETURN_INSTR && state_ff == cpr_pkg::ST_POP_RD);
    wrap_cov_c: cover property (stack_we_out && sp_ff == 6'h00);

    function automatic logic uw_en_cc();
        return uw_en && uw_sel == cpr_pkg::REG_CC;
    endfunction : uw_en_cc

    function automatic logic uw_en_sl();
        return uw_en && uw_sel == cpr_pkg::REG_SL;
    endfunction : uw_en_sl

endmodule : cpr_regs

`default_nettype wire

// File: tb/cpr_regs_bench.sv
// Self-checking bench for the register file against an integer model.
// Assumes the design package, the register file and the RAM model.
`timescale 1ns/100ps
`default_nettype none

module cpr_regs_bench;
    logic clk_in = 1'b0;
    logic rst_n = 1'b0;
    logic [18:0] pl = '0;
    logic adc = 1'b0;
    cpr_pkg::cpr_reg_t sel = cpr_pkg::REG_A;
    logic [7:0] dat = 8'h00;
    logic [7:0] opnd = 8'h00;
    logic [7:0] acc, ix, iy, cc, wd, rd, m_cc;
    logic [7:0] ctx [5];
    logic [15:0] pc, sp, addr;
    logic busy, we, pend, serv;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int m_acc = 0;
    int m_c = 0;
    logic [31:0] seed = 32'h08AE51E2;

    // ==========================================================
    // Design and partner
    cpr_regs i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n), .wr_en_in(pl[8]), .wr_sel_in(sel), .wr_data_in(dat),
        .res_we_in(pl[11]), .res_sel_in(sel), .res_data_in(dat), .add_go_in(pl[7]),
        .add_with_carry_in(adc), .add_opnd_in(opnd), .set_mask_instr_in(pl[1]),
        .clear_mask_instr_in(pl[0]), .set_carry_instr_in(pl[12]),
        .clear_carry_instr_in(pl[13]), .carry_wr_in(pl[14]), .carry_val_in(adc),
        .pc_we_in(pl[10]), .pc_load_in({dat, ~dat}), .pc_inc_in(pl[15]),
        .reset_stack_pointer_instr_in(pl[6]), .push_in(pl[4]), .pop_in(pl[5]),
        .stk_sel_in(sel), .call_in(pl[16]), .ret_in(pl[17]), .irq_enter_in(pl[2]),
        .trap_enter_in(pl[18]), .interrupt_return_instr_in(pl[3]), .stack_rdata_in(rd),
        .irq_req_in(pl[9]), .acc_out(acc), .idx_x_out(ix), .idx_y_out(iy),
        .program_counter_out(pc), .condition_code_register_out(cc), .stack_pointer_out(sp),
        .busy_out(busy), .stack_we_out(we), .stack_addr_out(addr), .stack_wdata_out(wd),
        .irq_pending_out(pend), .irq_service_out(serv)
    );
    cpr_stack_ram i_ram (.clk_in(clk_in), .we_in(we), .addr_in(addr), .wdata_in(wd),
        .rdata_out(rd));

    always #5 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // ==========================================================
    // Helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic pulse(input int b, input cpr_pkg::cpr_reg_t s, input logic [7:0] d);
        @(posedge clk_in);
        pl[b] <= 1'b1;
        sel <= s;
        dat <= d;
        @(posedge clk_in);
        pl <= '0;
        #1;
        for (int k = 0; k < 20 && busy !== 1'b0 && b != 2; k++)
            @(posedge clk_in) #1;
        #1;
    endtask : pulse

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n <= 1'b1;
        #1;
        check({acc, cc, sp}, 32'h00E800FF);
        pulse(9, cpr_pkg::REG_A, 8'h00);
        check({pend, serv}, 2'b10);
        pulse(0, cpr_pkg::REG_A, 8'h00);
        check({pend, serv}, 2'b11);
        $display("test mask done");
        for (int i = 0; i < 40; i++)
        begin
            int a, w, s, h;
            a = xs() % 256;
            w = xs() % 2;
            s = m_acc + a + w * m_c;
            h = (m_acc % 16 + a % 16 + w * m_c) > 15;
            m_cc = {3'b111, h[0], 1'b0, s[7], s[7:0] == 8'h00, s > 255};
            @(posedge clk_in);
            pl[7] <= 1'b1;
            opnd <= a[7:0];
            adc <= w[0];
            @(posedge clk_in);
            pl <= '0;
            #1;
            check({acc, cc}, {s[7:0], m_cc});
            m_acc = s % 256;
            m_c = s > 255;
        end
        $display("test add done");
        pulse(8, cpr_pkg::REG_X, 8'h5A);
        pulse(8, cpr_pkg::REG_Y, 8'h66);
        pulse(10, cpr_pkg::REG_A, 8'h3C);
        ctx = '{8'hC3, 8'h3C, 8'h5A, m_acc[7:0], m_cc};
        pulse(2, cpr_pkg::REG_A, 8'h00);
        for (int j = 0; j < 5; j++)
        begin
            check({busy, we, addr, wd}, {2'b11, 16'(255 - j), ctx[j]});
            @(posedge clk_in);
            #1;
        end
        check({busy, pend, cc[3], sp}, {3'b001, 16'h00FA});
        pulse(8, cpr_pkg::REG_A, 8'h11);
        pulse(8, cpr_pkg::REG_X, 8'h22);
        pulse(3, cpr_pkg::REG_A, 8'h00);
        check({acc, ix, iy, pc, cc, sp}, {m_acc[7:0], 24'h5A663C, 8'hC3, m_cc, 16'h00FF});
        $display("test interrupt done");
        pulse(8, cpr_pkg::REG_SL, 8'h40);
        check(sp, 16'h00C0);
        pulse(4, cpr_pkg::REG_A, 8'h00);
        check(sp, 16'h00FF);
        pulse(5, cpr_pkg::REG_X, 8'h00);
        check({ix, sp}, {m_acc[7:0], 16'h00C0});
        pulse(6, cpr_pkg::REG_A, 8'h00);
        check(sp, 16'h00FF);
        $display("test stack done");
        pulse(1, cpr_pkg::REG_A, 8'h00);
        pulse(12, cpr_pkg::REG_A, 8'h00);
        check(cc[3:0], {1'b1, m_cc[2:1], 1'b1});
        pulse(11, cpr_pkg::REG_Y, 8'h80);
        check({iy, cc[2:1]}, 10'h202);
        pulse(13, cpr_pkg::REG_A, 8'h00);
        pulse(16, cpr_pkg::REG_A, 8'h00);
        check({cc[0], sp}, 17'h000FD);
        pulse(17, cpr_pkg::REG_A, 8'h00);
        check({pc, sp}, 32'h3CC300FF);
        $display("test flags done");
        print_verdict();
    end
endmodule : cpr_regs_bench

`default_nettype wire

// File: tb/cpr_stack_ram.sv
// Stack RAM model standing beside the register file.
// Assumes one clock; reads are combinational at the given address.
`timescale 1ns/100ps
`default_nettype none

module cpr_stack_ram (
    // Clock and port
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [256];

    // ==========================================================
    // Storage
    always_ff @(posedge clk_in)
    begin
        if (we_in)
        begin
            mem[addr_in[7:0]] <= wdata_in;
        end
    end

    assign rdata_out = mem[addr_in[7:0]];
endmodule : cpr_stack_ram

`default_nettype wire
